// >>> verif/nvsc_dev_model.sv
// behavioural model of the nonvolatile sram behind the host controller
`timescale 1ns/1ps
module nvsc_dev_model
    import nvsc_pkg::*;
#(
    parameter int NV_NS = 600
) (
    // memory pins
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    // power monitor
    input  wire logic              pwr_fail
);
    logic [DATA_W-1:0] sram [0:32767];
    logic [DATA_W-1:0] nv   [0:32767];
    logic [13:0]       lead [0:4] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
    logic [DATA_W-1:0] q = 8'h00;
    logic [2:0]        step = 3'h0;
    logic              busy = 1'b0;
    logic              written = 1'b0;
    logic              pf = 1'b0;
    logic              wr_act = 1'b0;
    logic              rd_act = 1'b0;
    wire               sel = !ce_n && !oe_n && we_n && !busy;
    wire               drive;
    // data follows address; a released bus shows the inverse at once
    assign drive = sel;
    always @(*) if (sel) q = sram[addr_in];
    assign data_out = drive ? q : ~q;
    // save copies array to nv, restore loads it back; pins ignored meanwhile
    task automatic nv_op(input logic save);
        int k;
        busy = 1'b1;
        #(NV_NS);
        for (k = 0; k < 32768; k++) begin
            if (save) nv[k] = sram[k];
            else sram[k] = nv[k];
        end
        written = 1'b0;
        busy = 1'b0;
    endtask
    // access start: write or sequence read
    always @(negedge ce_n or negedge we_n) begin
        wr_act = !ce_n && !we_n && !busy && !pf;
        rd_act = !ce_n && we_n && !busy;
    end
    // access end: capture write data or step the sequence
    always @(posedge ce_n or posedge we_n) begin
        if (wr_act) begin
            sram[addr_in] = data_in;
            written = 1'b1;
            step = 3'h0;
        end else if (rd_act && ce_n) begin
            if (step < 3'h5 && addr_in[13:0] == lead[step]) step = step + 3'h1;
            else if (step == 3'h5 && (addr_in[13:0] == SEQ_SAVE || addr_in[13:0] == SEQ_RESTORE)) begin
                step = 3'h0;
                if (addr_in[13:0] == SEQ_RESTORE) nv_op(1'b0);
                else if (!pf) nv_op(1'b1);
            end else step = (addr_in[13:0] == SEQ_A1) ? 3'h1 : 3'h0;
        end
        wr_act = 1'b0;
        rd_act = 1'b0;
    end
    // power fail: isolate, save if written, restore when power returns
    always @(posedge pwr_fail) begin
        pf = 1'b1;
        #150;
        if (written) nv_op(1'b1);
    end
    always @(negedge pwr_fail) begin
        pf = 1'b0;
        nv_op(1'b0);
    end
    // blank arrays at start
    initial begin
        for (int k = 0; k < 32768; k++) begin
            sram[k] = 8'h00;
            nv[k] = 8'h00;
        end
    end
endmodule

// >>> verif/tb.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps
module tb import nvsc_pkg::*;;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              cmd_valid = 1'b0;
    nvsc_cmd_t         cmd_op = NVSC_CMD_READ;
    logic [ADDR_W-1:0] cmd_addr = 15'h0000;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    logic              pwr_fail = 1'b0;
    logic              cmd_ready, rsp_valid, nv_busy, ce_n, oe_n, we_n, data_io_oe;
    logic [DATA_W-1:0] rsp_rdata, data_io_o, dev_q, rd;
    logic [ADDR_W-1:0] addr_in;
    wire  [DATA_W-1:0] bus = data_io_oe ? data_io_o : dev_q;
    logic [ADDR_W-1:0] aq [$];
    logic [13:0]       lead [0:4] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
    int                errors = 0;
    int                comparisons = 0;
    // clock and address log of every chip-enable pulse
    always #50 core_clk = ~core_clk;
    always @(negedge ce_n) aq.push_back(addr_in);
    nvsc_host #(.SAVE_WAIT(10), .RESTORE_WAIT(10), .PU_WAIT(10)) i_dut (
        .CORE_CLK(core_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .PWR_FAIL(pwr_fail), .NV_BUSY(nv_busy), .ADDR_IN(addr_in), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
        .DATA_IO_I(bus), .DATA_IO_O(data_io_o), .DATA_IO_OE(data_io_oe));
    nvsc_dev_model i_mem (.addr_in(addr_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .data_in(bus),
        .data_out(dev_q), .pwr_fail(pwr_fail));
    // compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic timeout;
        errors++;
        results();
    endtask
    // one command: wait ready, take, watch pins, collect response
    task automatic cmd(input nvsc_cmd_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
        int n;
        aq.delete();
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) timeout();
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) begin
            @(negedge core_clk);
            if (ce_n === 1'b0 && op >= NVSC_CMD_SAVE) check(16'({we_n, data_io_oe}), 16'h0002);
            else if (ce_n === 1'b0) check(16'({oe_n, we_n, data_io_oe}),
                op == NVSC_CMD_WRITE ? 16'h0005 : 16'h0002);
        end
        if (n == 200) timeout();
        q = rsp_rdata;
        if (op >= NVSC_CMD_SAVE) begin
            check(16'(aq.size()), 16'h0006);
            for (n = 0; n < 6; n++) check(16'(aq[n]), 16'({1'b0, n < 5 ? lead[n] :
                op == NVSC_CMD_SAVE ? SEQ_SAVE : SEQ_RESTORE}));
        end else check(16'({aq.size() == 1, aq[0]}), 16'({1'b1, a}));
    endtask
    // writes then reads at address extremes
    task automatic t_rdwr;
        logic [ADDR_W-1:0] a [0:3] = '{15'h0000, 15'h7fff, 15'h1234, 15'h4e38};
        for (int k = 0; k < 4; k++) cmd(NVSC_CMD_WRITE, a[k], a[k][7:0] ^ 8'h5a, rd);
        for (int k = 0; k < 4; k++) begin
            cmd(NVSC_CMD_READ, a[k], 8'h00, rd);
            check(16'(rd), 16'(a[k][7:0] ^ 8'h5a));
        end
    endtask
    // save, overwrite, restore brings back the saved byte
    task automatic t_nv;
        cmd(NVSC_CMD_WRITE, 15'h0100, 8'ha5, rd);
        cmd(NVSC_CMD_SAVE, 15'h0000, 8'h00, rd);
        cmd(NVSC_CMD_WRITE, 15'h0100, 8'h3c, rd);
        cmd(NVSC_CMD_READ, 15'h0100, 8'h00, rd);
        check(16'(rd), 16'h003c);
        cmd(NVSC_CMD_RESTORE, 15'h0000, 8'h00, rd);
        cmd(NVSC_CMD_READ, 15'h0100, 8'h00, rd);
        check(16'(rd), 16'h00a5);
    endtask
    // power fail saves the written byte, power return restores it
    task automatic t_pwr;
        int n;
        cmd(NVSC_CMD_WRITE, 15'h0200, 8'hc3, rd);
        pwr_fail = 1'b1;
        repeat (20) @(negedge core_clk);
        check(16'({cmd_ready, nv_busy}), 16'h0001);
        pwr_fail = 1'b0;
        for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) timeout();
        cmd(NVSC_CMD_READ, 15'h0200, 8'h00, rd);
        check(16'(rd), 16'h00c3);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (2) @(negedge core_clk);
        check(16'({ce_n, oe_n, we_n, data_io_oe, nv_busy, cmd_ready}), 16'h0038);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_rdwr();
        t_nv();
        t_pwr();
        results();
    end
endmodule

// >>> verilog/nvsc_host.sv
// host controller driving the nonvolatile sram pins
`timescale 1ns/1ps
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int SAVE_WAIT    = SAVE_CYC,
    parameter int RESTORE_WAIT = RESTORE_CYC,
    parameter int PU_WAIT      = PU_RESTORE_CYC
) (
    // clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    // user command port
    input  wire logic              CMD_VALID,
    input  wire nvsc_cmd_t         CMD_OP,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [DATA_W-1:0] CMD_WDATA,
    output logic                   CMD_READY,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_RDATA,
    // power monitor
    input  wire logic              PWR_FAIL,
    output logic                   NV_BUSY,
    // memory pins
    output logic [ADDR_W-1:0]      ADDR_IN,
    output logic                   CE_N,
    output logic                   OE_N,
    output logic                   WE_N,
    input  wire logic [DATA_W-1:0] DATA_IO_I,
    output logic [DATA_W-1:0]      DATA_IO_O,
    output logic                   DATA_IO_OE
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_WAIT, S_PWRDN} nvsc_state_t;

    localparam int CNT_W = 32;

    logic [DATA_W-1:0] din_sync;
    logic              pfail_sync;

    nvsc_sync #(.W(DATA_W + 1)) u_sync (
        .clk (CORE_CLK),
        .rst (RST),
        .d   ({PWR_FAIL, DATA_IO_I}),
        .q   ({pfail_sync, din_sync})
    );

    nvsc_state_t       state_reg, state_next;
    nvsc_cmd_t         op_reg, op_next;
    logic [2:0]        step_reg, step_next;
    logic [1:0]        tcnt_reg, tcnt_next;
    logic [CNT_W-1:0]  wcnt_reg, wcnt_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdat_reg, wdat_next;
    logic [DATA_W-1:0] rdat_reg, rdat_next;
    logic              rvld_reg, rvld_next;
    logic              ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next, doe_reg, doe_next;
    logic              pfd_reg;
    logic              rdy_reg, rdy_next, busy_reg, busy_next;

    // is the current op a six-step nonvolatile sequence
    function automatic logic is_nv(input nvsc_cmd_t op);
        is_nv = (op == NVSC_CMD_SAVE) || (op == NVSC_CMD_RESTORE);
    endfunction

    // next-state for access and sequence engine
    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        step_next  = step_reg;
        tcnt_next  = tcnt_reg;
        wcnt_next  = wcnt_reg;
        addr_next  = addr_reg;
        wdat_next  = wdat_reg;
        rdat_next  = rdat_reg;
        rvld_next  = 1'b0;
        ce_next    = ce_reg;
        oe_next    = oe_reg;
        we_next    = we_reg;
        doe_next   = doe_reg;
        rdy_next   = 1'b0;
        busy_next  = busy_reg;
        case (state_reg)
            S_IDLE: begin
                ce_next  = 1'b1;
                we_next  = 1'b1;
                oe_next  = 1'b1;
                doe_next = 1'b0;
                if (pfail_sync) begin
                    // device saves on its own; hold pins idle, issue no writes
                    state_next = S_PWRDN;
                    busy_next  = 1'b1;
                    addr_next  = '0; // park address while the device isolates
                end else if (CMD_VALID && rdy_reg) begin
                    op_next    = CMD_OP;
                    step_next  = 3'h0;
                    wdat_next  = CMD_WDATA;
                    tcnt_next  = SETUP_CYC;
                    state_next = S_SETUP;
                    // only lower bits carry the sequence; msb held low
                    if (is_nv(CMD_OP)) begin
                        addr_next = {1'b0, seq_addr(3'h0, CMD_OP == NVSC_CMD_SAVE)};
                    end else begin
                        addr_next = CMD_ADDR;
                    end
                end else begin
                    rdy_next = 1'b1;
                end
            end
            S_SETUP: begin
                // address stable before enables fall
                tcnt_next = tcnt_reg - 2'h1;
                if (tcnt_reg == 2'h1) begin
                    ce_next   = 1'b0;
                    tcnt_next = PULSE_CYC;
                    if (op_reg == NVSC_CMD_WRITE) begin
                        we_next  = 1'b0;
                        oe_next  = 1'b1;
                        doe_next = 1'b1;
                    end else begin
                        we_next = 1'b1;
                        oe_next = 1'b0;
                    end
                    state_next = S_PULSE;
                end
            end
            S_PULSE: begin
                tcnt_next = tcnt_reg - 2'h1;
                if (tcnt_reg == 2'h1) begin
                    rdat_next  = din_sync; // pin data already through the sync, enables still low
                    ce_next    = 1'b1;
                    we_next    = 1'b1;
                    oe_next    = 1'b1;
                    tcnt_next  = HOLD_CYC;
                    state_next = S_HOLD;
                end
            end
            S_HOLD: begin
                // data held past end of write, address past enable rise
                tcnt_next = tcnt_reg - 2'h1;
                if (tcnt_reg == 2'h1) begin
                    doe_next = 1'b0;
                    if (!is_nv(op_reg)) begin
                        rvld_next  = 1'b1;
                        state_next = S_IDLE;
                    end else if (step_reg == 3'(SEQ_LEN - 1)) begin
                        // sixth read issued; wait out the operation
                        busy_next  = 1'b1;
                        wcnt_next  = (op_reg == NVSC_CMD_SAVE) ? CNT_W'(SAVE_WAIT) : CNT_W'(RESTORE_WAIT);
                        state_next = S_WAIT;
                    end else begin
                        // back-to-back sequence reads, nothing interleaved
                        step_next  = step_reg + 3'h1;
                        addr_next  = {1'b0, seq_addr(step_reg + 3'h1, op_reg == NVSC_CMD_SAVE)};
                        tcnt_next  = SETUP_CYC;
                        state_next = S_SETUP;
                    end
                end
            end
            S_WAIT: begin
                // pins idle; data lines released
                wcnt_next = wcnt_reg - CNT_W'(1);
                if (wcnt_reg <= CNT_W'(1)) begin
                    busy_next  = 1'b0;
                    rvld_next  = 1'b1;
                    state_next = S_IDLE;
                end
            end
            S_PWRDN: begin
                // after power returns, wait the power-up restore
                if (!pfail_sync && pfd_reg) begin
                    wcnt_next  = CNT_W'(PU_WAIT);
                    op_next    = NVSC_CMD_RESTORE;
                    state_next = S_WAIT;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= S_IDLE;
            op_reg    <= NVSC_CMD_READ;
            step_reg  <= 3'h0;
            tcnt_reg  <= 2'h0;
            wcnt_reg  <= '0;
            addr_reg  <= '0;
            wdat_reg  <= '0;
            rdat_reg  <= '0;
            rvld_reg  <= 1'b0;
            ce_reg    <= 1'b1;
            oe_reg    <= 1'b1;
            we_reg    <= 1'b1;
            doe_reg   <= 1'b0;
            pfd_reg   <= 1'b0;
            rdy_reg   <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            step_reg  <= step_next;
            tcnt_reg  <= tcnt_next;
            wcnt_reg  <= wcnt_next;
            addr_reg  <= addr_next;
            wdat_reg  <= wdat_next;
            rdat_reg  <= rdat_next;
            rvld_reg  <= rvld_next;
            ce_reg    <= ce_next;
            oe_reg    <= oe_next;
            we_reg    <= we_next;
            doe_reg   <= doe_next;
            pfd_reg   <= pfail_sync;
            rdy_reg   <= rdy_next;
            busy_reg  <= busy_next;
        end
    end

    // outputs straight from flops
    assign ADDR_IN    = addr_reg;
    assign CE_N       = ce_reg;
    assign OE_N       = oe_reg;
    assign WE_N       = we_reg;
    assign DATA_IO_O  = wdat_reg;
    assign DATA_IO_OE = doe_reg;
    assign CMD_READY  = rdy_reg;
    assign RSP_VALID  = rvld_reg;
    assign RSP_RDATA  = rdat_reg;
    assign NV_BUSY    = busy_reg;

    // assertions
    sequence seq_read_pulse;
        !CE_N && WE_N;
    endsequence

    seq_we_high_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (is_nv(op_reg) && !CE_N) |-> WE_N) else $error("write enable low in sequence");
    no_contend_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        DATA_IO_OE |-> OE_N) else $error("output enable low while driving");
    busy_quiet_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (state_reg == S_WAIT) |-> (CE_N && !DATA_IO_OE)) else $error("pins active while busy");
    msb_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (is_nv(op_reg) && state_reg != S_IDLE && state_reg != S_PWRDN) |-> !ADDR_IN[ADDR_W-1])
        else $error("sequence msb set");
    no_test_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CE_N |-> !(is_nv(op_reg) && ADDR_IN[13:0] == SEQ_TEST)) else $error("test address issued");
    // enable pulse lasts three cycles, matching the pulse count of the package
    read_step_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (is_nv(op_reg) && $fell(CE_N)) |-> seq_read_pulse [*3] ##1 CE_N) else $error("bad sequence pulse");
    addr_stable_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (!CE_N) |-> $stable(ADDR_IN)) else $error("address moved during access");
    pfail_block_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (state_reg == S_PWRDN) |-> (WE_N && CE_N)) else $error("access during power fail");
endmodule

// >>> verilog/nvsc_pkg.sv
// constants and types for the nonvolatile sram host controller
//------------------------------------------------------------
// Operation
// - every sequence step is a chip-enable read pulse
// - write enable stays high during sequence steps
// - five fixed lead-in reads in strict order
// - no foreign access inside a sequence
// - write when enable and write enable low
// - drivers off when write enable falls
// - save 10 ms, restore 20 us, inputs ignored
// - never issue the reserved 339c sequence
//------------------------------------------------------------
package nvsc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam logic [13:0] SEQ_A1 = 14'h0e38;
    localparam logic [13:0] SEQ_A2 = 14'h31c7;
    localparam logic [13:0] SEQ_A3 = 14'h03e0;
    localparam logic [13:0] SEQ_A4 = 14'h3c1f;
    localparam logic [13:0] SEQ_A5 = 14'h303f;
    localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
    localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
    localparam logic [13:0] SEQ_TEST = 14'h339c;
    localparam int CLK_NS = 100;
    localparam int SAVE_TIME_MS = 10;
    localparam int RESTORE_TIME_US = 20;
    localparam int PU_RESTORE_TIME_US = 650;
    localparam int SAVE_CYC = SAVE_TIME_MS * 1000000 / CLK_NS;
    localparam int RESTORE_CYC = RESTORE_TIME_US * 1000 / CLK_NS;
    localparam int PU_RESTORE_CYC = PU_RESTORE_TIME_US * 1000 / CLK_NS;
    // access timing, whole clock cycles; the pulse also spans the two-flop read data sync
    localparam logic [1:0] SETUP_CYC = 2'h1;
    localparam logic [1:0] PULSE_CYC = 2'h3;
    localparam logic [1:0] HOLD_CYC = 2'h1;
    typedef enum logic [1:0] {NVSC_CMD_READ, NVSC_CMD_WRITE, NVSC_CMD_SAVE, NVSC_CMD_RESTORE} nvsc_cmd_t;

    // table of sequence address by step index
    function automatic logic [13:0] seq_addr(input logic [2:0] idx, input logic save);
        case (idx)
            3'h0: seq_addr = SEQ_A1;
            3'h1: seq_addr = SEQ_A2;
            3'h2: seq_addr = SEQ_A3;
            3'h3: seq_addr = SEQ_A4;
            3'h4: seq_addr = SEQ_A5;
            default: seq_addr = save ? SEQ_SAVE : SEQ_RESTORE;
        endcase
    endfunction
endpackage

// >>> verilog/nvsc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nvsc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage read only by second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
